/* core/lpss_device.sv */
// Sensor-side sequencer: shift register, hold, integrator reset, output select
// Summary of operation
// - 128-stage shift register on rising edges
// - Readout begins when start sampled high
// - Controller drops start after one clock
// - Controller ties freeze to start
// - Freeze rising edge holds capacitors, resets integrators
// - Held scan result stays frozen during freeze
// - Each held pixel routed out per clock
// - Integrators held reset first 18 clocks
// - Integration restarts on 19th clock
// - 129th edge shifts pulse out, output off
// - Controller supplies the 129th clock
// - Next start after transfer delay only
// - Output high impedance outside output phase
// - Exiting pulse appears on chain output
// - Shortest integration is 110 clocks plus transfer
module lpss_device
  import lpss_pkg::*;
#(
  parameter int PIXELS       = LPSS_PIXELS,
  parameter int RESET_CLOCKS = LPSS_RESET_CLOCKS
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Link to controller
  lpss_link_if.device            link,
  // Status toward the analog core
  output logic                   integrator_reset,
  output logic                   capacitors_held,
  output logic                   output_active
);
  logic [PIXELS-1:0] shift_chain;
  logic              freeze_prev;
  logic [7:0]        reset_count;
  logic              freeze_rise;
  logic              chain_out;

  assign freeze_rise = link.sample_freeze_input && !freeze_prev;

  // Start pulse shifts through the chain; the last stage leaves on the 129th edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_chain <= '0;
    else
      shift_chain <= {shift_chain[PIXELS-2:0], link.scan_start_input};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      freeze_prev <= 1'b0;
    else
      freeze_prev <= link.sample_freeze_input;
  end

  // Hold: capacitors disconnected from the first freeze edge until reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      capacitors_held <= 1'b0;
    else if (freeze_rise)
      capacitors_held <= 1'b1;
  end

  // Integrator reset for the first clocks of the readout
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_count      <= 8'h00;
      integrator_reset <= 1'b0;
    end
    else if (freeze_rise)
    begin
      reset_count      <= 8'(RESET_CLOCKS - 1);
      integrator_reset <= 1'b1;
    end
    else if (reset_count != 8'h00)
      reset_count <= reset_count - 8'h01;
    else
      integrator_reset <= 1'b0;
  end

  // Output select: index of the stage currently holding the pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.pixel_index  <= 7'h00;
      output_active     <= 1'b0;
    end
    else
    begin
      output_active    <= link.scan_start_input;
      link.pixel_index <= 7'h00;
      for (int i = 1; i < PIXELS; i++)
        if (shift_chain[i-1])
        begin
          output_active    <= 1'b1;
          link.pixel_index <= 7'(i);
        end
    end
  end

  // Pulse leaving the last stage shows after the 129th edge, with the output off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chain_out <= 1'b0;
    else
      chain_out <= shift_chain[PIXELS-1];
  end

  assign link.pixel_analog_oe_n = !output_active;
  assign link.scan_chain_out    = chain_out;
endmodule : lpss_device

/* core/lpss_pkg.sv */
// Package of constants shared by the scan sequencer ends
package lpss_pkg;
  localparam int          LPSS_PIXELS       = 128;
  localparam int          LPSS_RESET_CLOCKS = 18;
  localparam int          LPSS_END_CLOCK    = LPSS_PIXELS + 1;
  localparam int          LPSS_CLK_NS       = 100;
  localparam int          LPSS_TRANSFER_NS  = 20000;
  localparam int          LPSS_TRANSFER_CYC = (LPSS_TRANSFER_NS + LPSS_CLK_NS - 1) / LPSS_CLK_NS;
  localparam int          LPSS_CNT_W        = 16;
endpackage : lpss_pkg

/* core/lpss_link_if.sv */
// Interface joining the scan controller and the sensor sequencer
interface lpss_link_if;
  logic       scan_start_input;
  logic       sample_freeze_input;
  logic       scan_chain_out;
  logic [6:0] pixel_index;
  logic       pixel_analog_oe_n;
  modport device (
    input  scan_start_input,
    input  sample_freeze_input,
    output scan_chain_out,
    output pixel_index,
    output pixel_analog_oe_n
  );
  modport host (
    output scan_start_input,
    output sample_freeze_input,
    input  scan_chain_out,
    input  pixel_index,
    input  pixel_analog_oe_n
  );
endinterface : lpss_link_if

/* core/lpss_host.sv */
// Scan controller: issues start/freeze pulse and clocks a full readout
module lpss_host
  import lpss_pkg::*;
#(
  parameter int TRANSFER_CYC = LPSS_TRANSFER_CYC
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // User side
  input  wire logic        scan_req,
  output logic             scan_busy,
  output logic             pixel_valid,
  output logic [6:0]       pixel_num,
  output logic             scan_done,
  // Link to sensor
  lpss_link_if.host        link
);
  typedef enum logic [2:0] {
    LPSS_IDLE  = 3'b001,
    LPSS_SCAN  = 3'b010,
    LPSS_WAIT  = 3'b100
  } lpss_state_t;
  lpss_state_t           state;
  logic [LPSS_CNT_W-1:0] count;
  logic                  start;

  assign start = (state == LPSS_IDLE) && scan_req;
  assign link.scan_start_input    = start;
  assign link.sample_freeze_input = start;
  assign scan_busy                = (state != LPSS_IDLE);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= LPSS_IDLE;
      count <= '0;
    end
    else
      case (state)
        LPSS_IDLE:
          if (start)
          begin
            state <= LPSS_SCAN;
            count <= '0;
          end
        LPSS_SCAN:
          if (count == LPSS_CNT_W'(LPSS_END_CLOCK - 2))
          begin
            state <= LPSS_WAIT;
            count <= '0;
          end
          else
            count <= count + 1'b1;
        LPSS_WAIT:
          if (count >= LPSS_CNT_W'(TRANSFER_CYC - 1))
            state <= LPSS_IDLE;
          else
            count <= count + 1'b1;
        default:
          state <= LPSS_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pixel_valid <= 1'b0;
      pixel_num   <= 7'h00;
      scan_done   <= 1'b0;
    end
    else
    begin
      pixel_valid <= !link.pixel_analog_oe_n;
      pixel_num   <= link.pixel_index;
      scan_done   <= link.scan_chain_out;
    end
  end
endmodule : lpss_host

/* test/lpss_chk.sv */
// Assertions on the scan link signals
module lpss_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link
  input wire logic       scan_start_input,
  input wire logic       sample_freeze_input,
  input wire logic       scan_chain_out,
  input wire logic [6:0] pixel_index,
  input wire logic       pixel_analog_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_start_opens:
    assert property (scan_start_input |=> !pixel_analog_oe_n && pixel_index == 7'h00)
    else $error("no open");
  chk_index_steps:
    assert property (!pixel_analog_oe_n && pixel_index != 7'h7F
      |=> pixel_index == $past(pixel_index) + 7'h01) else $error("bad step");
  chk_last_closes:
    assert property (!pixel_analog_oe_n && pixel_index == 7'h7F
      |=> pixel_analog_oe_n && scan_chain_out) else $error("no close");
  chk_scan_length:
    assert property (scan_start_input |-> ##128 !pixel_analog_oe_n ##1 pixel_analog_oe_n)
    else $error("bad length");
  chk_chain_single:
    assert property (scan_chain_out |=> !scan_chain_out) else $error("long chain");
  chk_idle_hiz:
    assert property (pixel_analog_oe_n && !scan_start_input |=> pixel_analog_oe_n)
    else $error("stray drive");
  chk_freeze_tied:
    assert property (scan_start_input == sample_freeze_input) else $error("untied");
  chk_start_single:
    assert property (scan_start_input |=> !scan_start_input) else $error("long start");
endmodule : lpss_chk

/* test/tb_linear_pixel_scan_sequencer.sv */
// Bench for the host and device ends joined by the link
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t mismatch", $time); end end
module tb_linear_pixel_scan_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TR = 2;
  logic clk, rst_n, req, done, ir, held, busy, act, pv;
  logic [6:0] pnum;
  int   n_fail = 0, checks = 0, n, k;
  lpss_link_if lk ();
  lpss_device u_lpss_device (.clk(clk), .rst_n(rst_n), .link(lk),
    .integrator_reset(ir), .capacitors_held(held), .output_active(act));
  lpss_host #(.TRANSFER_CYC(TR)) u_lpss_host (.clk(clk), .rst_n(rst_n), .scan_req(req),
    .scan_busy(busy), .pixel_valid(pv), .pixel_num(pnum), .scan_done(done), .link(lk));
  lpss_chk u_lpss_chk (.clk(clk), .rst_n(rst_n), .scan_start_input(lk.scan_start_input),
    .sample_freeze_input(lk.sample_freeze_input), .scan_chain_out(lk.scan_chain_out),
    .pixel_index(lk.pixel_index), .pixel_analog_oe_n(lk.pixel_analog_oe_n));
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic wait_start;
    n = 0;
    while (lk.scan_start_input !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_start
  task automatic t_scan;
    @(posedge clk) req <= 1'b1;
    wait_start;
    `CHK(lk.sample_freeze_input, 1'b1)
    @(posedge clk) req <= 1'b0;
    for (k = 0; k < 128; k++)
    begin
      @(negedge clk);
      `CHK({lk.pixel_analog_oe_n, lk.pixel_index}, {1'b0, k[6:0]})
      `CHK(ir, k < 18)
      `CHK({act, busy}, 2'b11)
      if (k > 0)
        `CHK({pv, pnum}, {1'b1, 7'(k - 1)})
    end
    @(negedge clk);
    `CHK({lk.pixel_analog_oe_n, lk.scan_chain_out, held}, 3'b111)
    n = 0;
    while (done !== 1'b1 && n < 9)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(done, 1'b1)
    $display("single scan finished");
  endtask : t_scan
  task automatic t_back;
    @(posedge clk) req <= 1'b1;
    wait_start;
    n = 0;
    while (lk.scan_chain_out !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    wait_start;
    `CHK(n >= TR, 1'b1)
    @(posedge clk) req <= 1'b0;
    repeat (140) @(negedge clk);
    `CHK(lk.pixel_analog_oe_n, 1'b1)
    $display("back to back scans finished");
  endtask : t_back
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0;
    req = 1'b0;
    repeat (4) @(posedge clk);
    `CHK(lk.pixel_analog_oe_n, 1'b1)
    rst_n <= 1'b1;
    t_scan;
    t_back;
    print_verdict;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule : tb_linear_pixel_scan_sequencer
